// *** common/btj_pkg.sv ***
// Package: constants and types for the bit-test jump decoder
package btj_pkg;

  localparam int WORD_W = 24;
  localparam int BITSEL_W = 5;
  localparam int BIT_MAX = 23;
  localparam logic [23:0] PERIPH_HIGH_BASE = 24'hFFFFC0;
  localparam logic [23:0] PERIPH_LOW_BASE = 24'hFFFF80;
  localparam logic [23:0] PC_RESET = 24'h000000;
  localparam logic [23:0] STK_PTR_RESET = 24'h000000;
  // Field positions in the opcode word
  localparam int SETBIT_POS = 5;
  localparam int SPACE_POS = 6;
  localparam int MODESEL_POS = 7;
  localparam int FIELD_LSB = 8;
  localparam int MODE_LSB = 11;

  typedef enum logic [5:0] {
    ST_FETCH = 6'h01,
    ST_EXT = 6'h02,
    ST_OPERAND = 6'h04,
    ST_TEST = 6'h08,
    ST_PUSH = 6'h10,
    ST_TARGET = 6'h20
  } btj_state_t;

  typedef enum logic [1:0] {
    SRC_MEM = 2'h0,
    SRC_REG = 2'h1
  } btj_src_t;

endpackage

// *** core/btj_addr_update.sv ***
// Register-indirect address computation and address register update
`timescale 1ns/10ps
module btj_addr_update
  import btj_pkg::*;
#(
  parameter int AW = 24
)
(
  input wire logic [2:0] mode,
  input wire logic [AW-1:0] rn,
  input wire logic [AW-1:0] nn,
  output logic [AW-1:0] effAddr,
  output logic [AW-1:0] rnNext,
  output logic updates
);
  always_comb
  begin
    effAddr = rn;
    rnNext = rn;
    updates = 1'b1;
    case (mode)
      3'h0:
      begin
        rnNext = rn - nn;
      end
      3'h1:
      begin
        rnNext = rn + nn;
      end
      3'h2:
      begin
        rnNext = rn - AW'(1);
      end
      3'h3:
      begin
        rnNext = rn + AW'(1);
      end
      3'h4:
      begin
        updates = 1'b0;
      end
      3'h5:
      begin
        effAddr = rn + nn;
        updates = 1'b0;
      end
      3'h7:
      begin
        effAddr = rn - AW'(1);
        rnNext = rn - AW'(1);
      end
      default:
      begin
        updates = 1'b0;
      end
    endcase
  end
endmodule // btj_addr_update

// *** core/btj_decoder.sv ***
// Bit-test jump and subroutine-call decoder and sequencer
// Overview of operation
// RULE1: Jump-if-bit-one loads PC with 24-bit extension target when bit is one.
// RULE2: Opcode bit-number field selects tested bit 0 to 23.
// RULE3: Bit zero on jump-if-bit-one: PC passes instruction, target dropped.
// RULE4: Named address register updates regardless of branch outcome.
// RULE5: Tested operand may use every register-indirect mode.
// RULE6: Absolute-short operand reaches locations 0 to 63.
// RULE7: Peripheral-short windows of 64 at FFFFC0 and FFFF80, six-bit offset.
// RULE8: Register variant tests any on-chip register by six-bit code.
// RULE9: Branch target is a full 24-bit second instruction word.
// RULE10: Call increments stack pointer, pushes return high and status low.
// RULE11: Call then fetches at target from operand location.
// RULE12: Call accepts every memory-alterable mode for its target.
// RULE13: Call has a short form with target inside opcode.
// RULE14: Short-form 12-bit target is zero-extended.
// RULE15: Call-if-bit-one with bit one pushes return address and status.
// RULE16: Call-if-bit-one then continues at 24-bit extension target.
// RULE17: Call-if-bit-one with bit zero pushes nothing and skips.
// RULE18: Call-if-bit-zero pushes and branches when tested bit is zero.
// RULE19: One opcode bit separates set-test and clear-test variants.
// RULE20: Extension word is fetched even on a branch not taken.
`timescale 1ns/10ps
module btj_decoder
  import btj_pkg::*;
#(
  parameter int AW = 24
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [AW-1:0] progData,
  input wire logic progValid,
  output logic [AW-1:0] progAddr,
  output logic [AW-1:0] dataAddr,
  output logic dataSpace,
  output logic [5:0] regCode,
  output logic operandReq,
  output logic operandIsReg,
  input wire logic [WORD_W-1:0] operandData,
  input wire logic operandValid,
  output logic [2:0] addrRegSel,
  input wire logic [AW-1:0] addrRegVal,
  input wire logic [AW-1:0] offsetRegVal,
  output logic addrRegWe,
  output logic [AW-1:0] addrRegWdata,
  input wire logic [WORD_W-1:0] statusWord,
  output logic stackWe,
  output logic [AW-1:0] stackHighWord,
  output logic [WORD_W-1:0] stackLowWord,
  output logic [AW-1:0] stackPointer,
  output logic [AW-1:0] pc,
  output logic illegalOp
);
  if (AW != WORD_W)
  begin : g_widthCheck
    $error("btj_decoder: AW must equal the word width");
  end

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic isBitTest(input logic [23:0] w);
    // Bit 4 belongs to the bit number; mode 11 with bit 7 set is a plain call or an illegal op
    isBitTest = (w[23:17] == 7'h05 && w[15:14] != 2'h3 && w[7] == 1'b1) ||
                (w[23:17] == 7'h05 && w[15:14] == 2'h3 && w[7:6] == 2'h0) ||
                (w[23:16] == 8'h01 && w[15] == 1'b1 && w[7] == 1'b1);
  endfunction

  function automatic logic [23:0] zext12(input logic [11:0] v);
    zext12 = {12'h000, v};
  endfunction

  btj_state_t state_q, state_d;
  logic [23:0] op_q, op_d;
  logic [AW-1:0] pc_q, pc_d, tgt_q, tgt_d, stkPtr_q, stkPtr_d, dAddr_q, dAddr_d;
  logic [AW-1:0] retAddr_q, retAddr_d;
  logic isCall_q, isCall_d, taken_q, taken_d, isReg_q, isReg_d, ill_q, ill_d;
  logic stackWe_q, stackWe_d, rWe_q, rWe_d;
  logic [AW-1:0] rW_q, rW_d;
  logic [AW-1:0] effAddr, rnNext;
  logic rnUpdates;

  btj_addr_update #(.AW(AW)) uAddr (
    .mode(progData[13:11]),
    .rn(addrRegVal),
    .nn(offsetRegVal),
    .effAddr(effAddr),
    .rnNext(rnNext),
    .updates(rnUpdates)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb
  begin
    state_d = state_q;
    op_d = op_q;
    pc_d = pc_q;
    tgt_d = tgt_q;
    stkPtr_d = stkPtr_q;
    dAddr_d = dAddr_q;
    retAddr_d = retAddr_q;
    isCall_d = isCall_q;
    taken_d = taken_q;
    isReg_d = isReg_q;
    ill_d = 1'b0;
    stackWe_d = 1'b0;
    rWe_d = 1'b0;
    rW_d = rW_q;
    case (state_q)
      ST_FETCH:
      begin
        if (progValid)
        begin
          op_d = progData;
          pc_d = pc_q + AW'(1);
          if (isBitTest(progData))
          begin
            // The low peripheral short form uses bit 14 to pick call over jump; the other forms use bit 16
            isCall_d = (progData[23:17] == 7'h00) ? progData[14] : progData[16];
            isReg_d = (progData[7] == 1'b0); // RULE8
            if (progData[23:17] == 7'h00)
              dAddr_d = PERIPH_LOW_BASE | AW'(progData[13:8]); // RULE7
            else if (progData[15:14] == 2'h1)
            begin
              dAddr_d = effAddr; // RULE5
              rWe_d = rnUpdates; // RULE4
              rW_d = rnNext; // RULE4
            end
            else if (progData[15:14] == 2'h2)
              dAddr_d = PERIPH_HIGH_BASE | AW'(progData[13:8]); // RULE7
            else
              dAddr_d = AW'(progData[13:8]); // RULE6
            state_d = ST_EXT; // RULE20
          end
          else if (progData[23:12] == 12'h0D0)
          begin
            tgt_d = zext12(progData[11:0]); // RULE13 RULE14
            retAddr_d = pc_q + AW'(1);
            state_d = ST_PUSH;
          end
          else if (progData[23:14] == 10'h02F && progData[7:0] == 8'h80)
          begin
            tgt_d = effAddr; // RULE12
            rWe_d = rnUpdates; // RULE4
            rW_d = rnNext;
            retAddr_d = pc_q + AW'(1);
            state_d = ST_PUSH;
          end
          else
            ill_d = 1'b1;
        end
      end
      ST_EXT:
      begin
        if (progValid)
        begin
          tgt_d = progData; // RULE9
          pc_d = pc_q + AW'(1); // RULE20
          retAddr_d = pc_q + AW'(1);
          state_d = ST_OPERAND;
        end
      end
      ST_OPERAND:
      begin
        if (operandValid)
        begin
          // Set-test versus clear-test: opcode bit 5 only
          taken_d = operandData[op_q[4:0]] == op_q[SETBIT_POS]; // RULE2 RULE19 RULE18
          if (op_q[4:0] > 5'(BIT_MAX))
            taken_d = 1'b0;
          state_d = ST_TEST;
        end
      end
      ST_TEST:
      begin
        if (!taken_q)
          state_d = ST_FETCH; // RULE3 RULE17
        else if (isCall_q)
          state_d = ST_PUSH; // RULE15
        else
        begin
          pc_d = tgt_q; // RULE1
          state_d = ST_FETCH;
        end
      end
      ST_PUSH:
      begin
        stkPtr_d = stkPtr_q + AW'(1); // RULE10
        stackWe_d = 1'b1; // RULE10
        state_d = ST_TARGET;
      end
      ST_TARGET:
      begin
        pc_d = tgt_q; // RULE11 RULE16
        state_d = ST_FETCH;
      end
      default:
      begin
        state_d = ST_FETCH;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= ST_FETCH;
      op_q <= 24'h000000;
      pc_q <= PC_RESET;
      tgt_q <= 24'h000000;
      stkPtr_q <= STK_PTR_RESET;
      dAddr_q <= 24'h000000;
      retAddr_q <= 24'h000000;
      isCall_q <= 1'b0;
      taken_q <= 1'b0;
      isReg_q <= 1'b0;
      ill_q <= 1'b0;
      stackWe_q <= 1'b0;
      rWe_q <= 1'b0;
      rW_q <= 24'h000000;
    end
    else
    begin
      state_q <= state_d;
      op_q <= op_d;
      pc_q <= pc_d;
      tgt_q <= tgt_d;
      stkPtr_q <= stkPtr_d;
      dAddr_q <= dAddr_d;
      retAddr_q <= retAddr_d;
      isCall_q <= isCall_d;
      taken_q <= taken_d;
      isReg_q <= isReg_d;
      ill_q <= ill_d;
      stackWe_q <= stackWe_d;
      rWe_q <= rWe_d;
      rW_q <= rW_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Status word is sampled live at the push; it must be stable in ST_PUSH+1
  assign progAddr = pc_q;
  assign pc = pc_q;
  assign dataAddr = dAddr_q;
  assign dataSpace = op_q[SPACE_POS];
  assign regCode = op_q[13:8];
  assign operandIsReg = isReg_q;
  assign operandReq = (state_q == ST_OPERAND);
  assign addrRegSel = (state_q == ST_FETCH) ? progData[10:8] : op_q[10:8];
  assign addrRegWe = rWe_q;
  assign addrRegWdata = rW_q;
  assign stackWe = stackWe_q;
  assign stackHighWord = retAddr_q;
  assign stackLowWord = statusWord;
  assign stackPointer = stkPtr_q;
  assign illegalOp = ill_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_jumpTaken;
    @(posedge clk) disable iff (!arst_n)
    (state_q == ST_TEST && taken_q && !isCall_q) |=> (pc_q == $past(tgt_q));
  endproperty
  a_jumpTaken: assert property (p_jumpTaken) else $error("taken jump missed target"); // RULE1

  property p_notTaken;
    @(posedge clk) disable iff (!arst_n)
    (state_q == ST_TEST && !taken_q) |=> (pc_q == $past(pc_q) && state_q == ST_FETCH && !stackWe);
  endproperty
  a_notTaken: assert property (p_notTaken) else $error("untaken branch changed pc"); // RULE3

  property p_extFetched;
    @(posedge clk) disable iff (!arst_n)
    (state_q == ST_EXT && progValid) |=> (pc_q == $past(pc_q) + AW'(1));
  endproperty
  a_extFetched: assert property (p_extFetched) else $error("extension word not consumed"); // RULE20

  sequence s_push;
    state_q == ST_PUSH ##1 stackWe;
  endsequence
  property p_pushSp;
    @(posedge clk) disable iff (!arst_n)
    (state_q == ST_PUSH) |-> s_push ##0 (stackPointer == $past(stkPtr_q) + AW'(1));
  endproperty
  a_pushSp: assert property (p_pushSp) else $error("push without sp increment"); // RULE10

  property p_callTarget;
    @(posedge clk) disable iff (!arst_n)
    (state_q == ST_PUSH) |-> ##2 (pc_q == $past(tgt_q, 2) && state_q == ST_FETCH);
  endproperty
  a_callTarget: assert property (p_callTarget) else $error("call did not reach target"); // RULE11

  property p_callNoPush;
    @(posedge clk) disable iff (!arst_n)
    (state_q == ST_TEST && !taken_q) |-> ##1 !stackWe ##1 !stackWe;
  endproperty
  a_callNoPush: assert property (p_callNoPush) else $error("push on untaken call"); // RULE17

  property p_shortZext;
    @(posedge clk) disable iff (!arst_n)
    (state_q == ST_FETCH && progValid && progData[23:12] == 12'h0D0)
      |=> (tgt_q == {12'h000, $past(progData[11:0])});
  endproperty
  a_shortZext: assert property (p_shortZext) else $error("short target not zero-extended"); // RULE14

  property p_periphHigh;
    @(posedge clk) disable iff (!arst_n)
    (state_q == ST_EXT && op_q[23:17] == 7'h05 && op_q[15:14] == 2'h2 && op_q[7])
      |-> (dataAddr[23:6] == PERIPH_HIGH_BASE[23:6]);
  endproperty
  a_periphHigh: assert property (p_periphHigh) else $error("peripheral window wrong"); // RULE7

endmodule // btj_decoder

// *** test/bit_test_jump_decoder_tb.sv ***
// Self-checking bench for the bit-test jump decoder
`timescale 1ns/10ps
module bit_test_jump_decoder_tb;
  logic [23:0] progData, progAddr, dataAddr, operandData, addrRegVal, offsetRegVal, addrRegWdata;
  logic [23:0] statusWord, stackHighWord, stackLowWord, stackPointer, pc;
  logic [23:0] nPush, nAw, nOp, nIll, capHi, capLo, capW, capA, base, stkExp;
  logic [5:0] regCode, capCode;
  logic [2:0] addrRegSel, capSel;
  logic clk, arst_n, progValid, dataSpace, operandReq, operandIsReg, addrRegWe, stackWe, illegalOp;
  logic capReg, capSpace;
  logic operandValid = 1'b0;
  logic stall = 1'b0;
  logic [31:0] lfsr = 32'h9037;
  int mismatches, n_checks;

  btj_decoder u_dut (.clk(clk), .arst_n(arst_n), .progData(progData), .progValid(progValid),
    .progAddr(progAddr), .dataAddr(dataAddr), .dataSpace(dataSpace), .regCode(regCode),
    .operandReq(operandReq), .operandIsReg(operandIsReg), .operandData(operandData),
    .operandValid(operandValid), .addrRegSel(addrRegSel), .addrRegVal(addrRegVal),
    .offsetRegVal(offsetRegVal), .addrRegWe(addrRegWe), .addrRegWdata(addrRegWdata),
    .statusWord(statusWord), .stackWe(stackWe), .stackHighWord(stackHighWord),
    .stackLowWord(stackLowWord), .stackPointer(stackPointer), .pc(pc), .illegalOp(illegalOp));
  btj_prog_mem u_mem (.clk(clk), .stall(stall), .progAddr(progAddr), .progData(progData),
    .progValid(progValid));

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'hA3000000) : (s >> 1);
  endfunction

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // Random stalls and pulse capture
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (stackWe === 1'b1)
    begin
      nPush <= nPush + 24'h000001;
      capHi <= stackHighWord;
      capLo <= stackLowWord;
    end
    if (addrRegWe === 1'b1)
    begin
      nAw <= nAw + 24'h000001;
      capW <= addrRegWdata;
      capSel <= addrRegSel;
    end
    if (operandReq === 1'b1 && operandValid === 1'b1)
    begin
      nOp <= nOp + 24'h000001;
      {capA, capReg, capCode, capSpace} <= {dataAddr, operandIsReg, regCode, dataSpace};
    end
    if (illegalOp === 1'b1)
      nIll <= nIll + 24'h000001;
    #1;
    lfsr <= nxt(lfsr);
    stall <= lfsr[5] & lfsr[6];
    operandValid <= operandReq & lfsr[3];
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (mismatches == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // One instruction of form f, optional forced bit number bo
  // ----------------------------------------
  task automatic run(input int f, input int bo);
    logic [31:0] s;
    logic [23:0] op, ext, opv, rn, npc, ret, updAddr;
    logic [4:0] b;
    logic [2:0] m;
    logic tk, call;
    int k;
    @(posedge clk);
    #1;
    s = lfsr;
    m = s[17] ? 3'b011 : 3'b010;
    case (f)
      0: op = {7'h05, s[8], 2'b00, s[14:9], 1'b1, s[6:0]};
      1: op = {7'h05, s[8], 2'b10, s[14:9], 1'b1, s[6:0]};
      2: op = {8'h01, 1'b1, s[8], s[14:9], 1'b1, s[6:0]};
      3: op = {7'h05, s[8], 2'b01, m, s[11:9], 1'b1, s[6:0]};
      4: op = {7'h05, s[8], 2'b11, s[14:9], 2'b00, s[5:0]};
      5: op = {12'h0D0, s[31:20]};
      6: op = 24'hFFFFFF;
      default: op = {8'h0B, 2'b11, m, s[11:9], 8'h80};
    endcase
    if (bo >= 0 && f < 5)
      op[4:0] = bo[4:0];
    {ext, opv, rn} = {s[31:8], s[15:0], s[31:24], s[7:0], s[31:16]};
    b = op[4:0];
    call = (f == 2) ? op[14] : op[16];
    tk = (b <= 5'd23) && (opv[b] === op[5]);
    npc = base + 24'h000002;
    ret = npc;
    if (tk)
      npc = ext;
    if (f >= 5)
      {tk, call, ret} = {2'b11, base + 24'h000001};
    if (f == 5)
      npc = {12'h000, op[11:0]};
    if (f == 6)
      {tk, npc} = {1'b0, base + 24'h000001};
    if (f == 7)
      npc = rn;
    updAddr = (m == 3'b011) ? rn + 24'h000001 : rn - 24'h000001;
    {nPush, nAw, nOp, nIll} = '0;
    {operandData, addrRegVal, offsetRegVal, statusWord} = {opv, rn, ~rn, ext ^ rn};
    u_mem.mem[base] = op;
    if (f < 5)
      u_mem.mem[base + 24'h000001] = ext;
    k = 0;
    for (int i = 0; i < 200 && k < 4; i++)
    begin
      @(posedge clk);
      #1;
      k = (pc === npc && operandReq === 1'b0) ? k + 1 : 0;
    end
    chk(24'(k), 24'h000004);
    chk(pc, npc);
    chk(nPush, {23'h0, call & tk});
    if (call & tk)
    begin
      stkExp = stkExp + 24'h000001;
      chk(capHi, ret);
      chk(capLo, ext ^ rn);
    end
    chk(stackPointer, stkExp);
    chk(nAw, {23'h0, f == 3 || f == 7});
    if (f == 3 || f == 7)
    begin
      chk(capW, updAddr);
      chk({21'h0, capSel}, {21'h0, op[10:8]});
    end
    chk(nIll, {23'h0, f == 6});
    chk(nOp, {23'h0, f < 5});
    if (f < 4)
      chk({23'h0, capSpace}, {23'h0, op[6]});
    case (f)
      0: chk(capA, {18'h0, op[13:8]});
      1: chk(capA, 24'hFFFFC0 + {18'h0, op[13:8]});
      2: chk(capA, 24'hFFFF80 + {18'h0, op[13:8]});
      3: chk(capA, rn);
      4: chk({17'h0, capReg, capCode}, {18'h1, op[13:8]});
      default: ;
    endcase
    u_mem.mem.delete(base);
    u_mem.mem.delete(base + 24'h000001);
    base = npc;
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    {arst_n, mismatches, n_checks, base, stkExp} = '0;
    {operandData, addrRegVal, offsetRegVal, statusWord} = '0;
    repeat (4) @(posedge clk);
    #1;
    arst_n = 1'b1;
    chk(pc, 24'h000000);
    chk(stackPointer, 24'h000000);
    run(0, 23);
    run(4, 0);
    run(1, 24);
    run(2, 31);
    run(3, 5);
    run(5, -1);
    run(6, -1);
    run(7, -1);
    for (int i = 0; i < 80; i++)
      run(lfsr[31:29], -1);
    final_report();
  end

  // Leaves every run its full 200-cycle wait before giving up
  initial
  begin
    #200000;
    mismatches++;
    final_report();
  end
endmodule // bit_test_jump_decoder_tb

// *** test/btj_prog_mem.sv ***
// Program memory model answering opcode and extension word fetches
`timescale 1ns/10ps
module btj_prog_mem
(
  input wire logic clk,
  input wire logic stall,
  input wire logic [23:0] progAddr,
  output logic [23:0] progData,
  output logic progValid
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [23:0] mem [logic [23:0]];

  initial
  begin
    progData = 24'h000000;
    progValid = 1'b0;
  end

  // Only loaded words answer, so a runaway fetch waits instead of eating junk
  always @(negedge clk)
  begin
    if (!stall && mem.exists(progAddr))
    begin
      progValid = 1'b1;
      progData = mem[progAddr];
    end
    else
    begin
      progValid = 1'b0;
      progData = ~progData;
    end
  end
endmodule // btj_prog_mem
